// ===== shared/hap_pkg.sv
// shared constants for the haptic trigger and mode control block
package hap_pkg;
   // ----------------------------------------
   // device register map
   // ----------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h01;
   localparam logic [7:0] REG_RTP = 8'h02;
   localparam logic [7:0] REG_SEQ_FIRST = 8'h04;
   localparam logic [7:0] REG_SEQ_LAST = 8'h0b;
   localparam logic [7:0] REG_FIRE = 8'h0c;
   localparam logic [7:0] REG_CFG_FIRST = 8'h16;
   localparam logic [7:0] REG_CFG_LAST = 8'h1a;
   localparam logic [7:0] REG_GATE = 8'h1d;
   localparam logic [7:0] REG_SUPPLY = 8'h21;
   localparam int SEQ_SLOTS = 8;
   localparam int CFG_REGS = 5;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int STAT_SHORT_BIT = 0;
   localparam int STAT_HOT_BIT = 1;
   localparam int MODE_LSB = 0;
   localparam int STANDBY_BIT = 6;
   localparam int SOFTRST_BIT = 7;
   localparam int GATE_LSB = 0;
   localparam int INSEL_BIT = 2;
   localparam int FIRE_BIT = 0;
   localparam int SLOT_WAIT_BIT = 7;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] MODE_RESET = 8'h40;
   localparam logic [7:0] ZERO8 = 8'h00;
   // ----------------------------------------
   // modes
   // ----------------------------------------
   localparam logic [2:0] MODE_INTERNAL = 3'h0;
   localparam logic [2:0] MODE_EDGE = 3'h1;
   localparam logic [2:0] MODE_LEVEL = 3'h2;
   localparam logic [2:0] MODE_INPUT = 3'h3;
   localparam logic [2:0] MODE_REALTIME = 3'h5;
   localparam logic [2:0] MODE_DIAG = 3'h6;
   localparam logic [2:0] MODE_CAL = 3'h7;
   // noise gate thresholds per 2-bit setting
   localparam logic [3:0][7:0] GATE_LEVELS = {8'h10, 8'h08, 8'h04, 8'h00};
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned WAIT_STEP_NS = 10000000;
   localparam int unsigned WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
   localparam int unsigned SHORT_CHECK_NS = 1000000;
   localparam int unsigned SHORT_CHECK_CYCLES = SHORT_CHECK_NS / CLK_PERIOD_NS;
   localparam int unsigned TRIG_PULSE_NS = 1000;
   localparam int unsigned TRIG_PULSE_CYCLES = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // controller register map (AHB byte addresses)
   // ----------------------------------------
   localparam logic [7:0] HOST_CTRL = 8'h00;
   localparam logic [7:0] HOST_CMD = 8'h04;
   localparam logic [7:0] HOST_STAT = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TRIG_BIT = 1;
   localparam int CTRL_PULSE_BIT = 2;
   localparam int CMD_WRITE_BIT = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_REFUSED_BIT = 1;
   localparam int STAT_DATA_LSB = 8;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : hap_pkg

// ===== shared/hap_link_if.sv
// link between the haptic device and its host controller
`timescale 1ns/1ps
`default_nettype none
interface hap_link_if;
   logic trigPin;
   logic enPin;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (input trigPin, input enPin, input req, input we, input addr, input wdata,
                output ack, output rdata);
   modport host (output trigPin, output enPin, output req, output we, output addr, output wdata,
                 input ack, input rdata);
endinterface : hap_link_if
`default_nettype wire

// ===== rtl/hap_pin_sync.sv
// two-flop pin synchroniser with edge pulses
`timescale 1ns/1ps
`default_nettype none
module hap_pin_sync
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pin and result
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   import hap_pkg::*;
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } hap_sync_t;
   hap_sync_t q, d;
   always_comb
   begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end
   always_ff @(posedge clk)
   begin
      if (srst)
         q <= '0;
      else
         q <= d;
   end
   assign level = q.s2;
   assign rise = q.s2 & ~q.s3; // RULE_24
   assign fall = ~q.s2 & q.s3; // RULE_24
endmodule : hap_pin_sync
`default_nettype wire

// ===== rtl/hap_device.sv
// haptic device end: registers, trigger modes, fire logic, sequencer, power and faults
//
// How it works
// RULE_01 - edge mode: rising trigger sets fire, plays
// RULE_02 - edge mode: host clearing fire stops playback
// RULE_03 - edge mode: second rise while firing cancels
// RULE_04 - edge mode: falling trigger does nothing
// RULE_05 - level mode: fire follows the trigger pin
// RULE_06 - level mode: source holds pin whole waveform
// RULE_07 - noise gate drops small input amplitudes
// RULE_08 - supply reading refreshed during playback
// RULE_09 - programmed config restored after every reset
// RULE_10 - overheat shuts down, sets thermal flag
// RULE_11 - short latches flag, shuts down, rechecks
// RULE_12 - enable low means shutdown, registers kept
// RULE_13 - enable low: ack but no access
// RULE_14 - standby set at reset; keeps registers
// RULE_15 - standby stops playback immediately
// RULE_16 - soft reset restores defaults, self clears
// RULE_17 - mode field encoding with input select
// RULE_18 - fire plays queue, or runs cal/diag
// RULE_19 - internal mode: fire held until done
// RULE_20 - external modes: fire bit shows trigger
// RULE_21 - realtime/pulse modes fire without fire bit
// RULE_22 - short before play blocks until mode change
// RULE_23 - queue stops at zero or eight; waits
// RULE_24 - trigger pin synchronised, edges derived
`timescale 1ns/1ps
`default_nettype none
module hap_device
#(
   parameter int unsigned STEP_CYCLES = hap_pkg::WAIT_STEP_CYCLES,
   parameter int unsigned CHECK_CYCLES = hap_pkg::SHORT_CHECK_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link to host
   hap_link_if.dev link,
   // analog and fault sensing
   input wire logic overTemp,
   input wire logic shortDet,
   input wire logic [7:0] supplyLevel,
   input wire logic [7:0] inputAmp,
   // one-time-programmable store
   input wire logic otpWritten,
   input wire logic [hap_pkg::CFG_REGS*8-1:0] otpImage,
   // playback engine
   input wire logic waveDone,
   input wire logic procDone,
   output logic playing,
   output logic [6:0] waveId,
   output logic [7:0] driveAmp,
   output logic calRun,
   output logic diagRun,
   output logic active
);
   import hap_pkg::*;
   typedef enum logic [2:0] {SIDLE, SNEXT, SPLAY, SWAIT, SPROC} hap_seq_t;
   typedef struct packed {
      logic [SEQ_SLOTS-1:0][7:0] slot;
      logic [CFG_REGS-1:0][7:0] cfg;
      logic [7:0] modeReg;
      logic [7:0] realtime_amplitude_mode;
      logic [7:0] gate;
      logic [7:0] supply;
      logic fireBit;
      logic hotFlag;
      logic shortFlag;
      logic shortBlock;
      logic seqDone;
      logic otpLoad;
      hap_seq_t st;
      logic [3:0] idx;
      logic [6:0] steps;
      logic [31:0] tick;
      logic [31:0] check;
      logic ack;
      logic [7:0] rdata;
      logic playing;
      logic [6:0] waveId;
      logic [7:0] driveAmp;
      logic calRun;
      logic diagRun;
      logic active;
   } hap_dev_t;
   hap_dev_t q, d;
   logic enLvl, trigLvl, trigRise;
   logic [2:0] mode;
   logic inSel, running, cont, fire, up;
   logic [7:0] slotVal, thresh;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   hap_pin_sync u_trig (.clk(clk), .srst(srst), .pin(link.trigPin), .level(trigLvl), .rise(trigRise),
      .fall()); // RULE_24
   hap_pin_sync u_en (.clk(clk), .srst(srst), .pin(link.enPin), .level(enLvl), .rise(), .fall());
   // ----------------------------------------
   // decode
   // ----------------------------------------
   always_comb
   begin
      mode = q.modeReg[MODE_LSB +: 3];
      inSel = q.gate[INSEL_BIT]; // RULE_17
      cont = (mode == MODE_REALTIME) || (mode == MODE_INPUT && inSel); // RULE_21
      up = enLvl && !q.modeReg[STANDBY_BIT] && !q.modeReg[SOFTRST_BIT] && !q.hotFlag && !q.shortFlag;
      fire = cont || q.fireBit; // RULE_21
      running = q.st != SIDLE;
      slotVal = q.slot[q.idx[2:0]];
      thresh = GATE_LEVELS[q.gate[GATE_LSB +: 2]]; // RULE_07
   end
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      if (q.otpLoad)
      begin
         d.otpLoad = 1'b0;
         if (otpWritten)
            d.cfg = otpImage; // RULE_09
      end
      if (q.modeReg[SOFTRST_BIT])
      begin
         d = '0; // RULE_16
         d.modeReg = MODE_RESET;
         d.otpLoad = 1'b1; // RULE_09
      end
      else
      begin
         // register access; the ack is given even when shut down
         if (link.req)
         begin
            d.ack = 1'b1; // RULE_13
            d.rdata = ZERO8;
            if (enLvl && !link.we) // RULE_13
            begin
               if (link.addr == REG_STATUS)
               begin
                  d.rdata[STAT_SHORT_BIT] = q.shortFlag;
                  d.rdata[STAT_HOT_BIT] = q.hotFlag;
                  d.hotFlag = 1'b0;
               end
               else if (link.addr == REG_MODE)
                  d.rdata = q.modeReg;
               else if (link.addr == REG_RTP)
                  d.rdata = q.realtime_amplitude_mode;
               else if (link.addr >= REG_SEQ_FIRST && link.addr <= REG_SEQ_LAST)
                  d.rdata = q.slot[3'(link.addr - REG_SEQ_FIRST)];
               else if (link.addr == REG_FIRE)
                  d.rdata[FIRE_BIT] = q.fireBit; // RULE_20
               else if (link.addr >= REG_CFG_FIRST && link.addr <= REG_CFG_LAST)
                  d.rdata = q.cfg[3'(link.addr - REG_CFG_FIRST)];
               else if (link.addr == REG_GATE)
                  d.rdata = q.gate;
               else if (link.addr == REG_SUPPLY)
                  d.rdata = q.supply;
            end
            if (enLvl && link.we) // RULE_13
            begin
               if (link.addr == REG_MODE)
               begin
                  if (link.wdata[MODE_LSB +: 3] != mode)
                     d.shortBlock = 1'b0; // RULE_22
                  d.modeReg = link.wdata; // RULE_14 RULE_16
               end
               else if (link.addr == REG_RTP)
                  d.realtime_amplitude_mode = link.wdata;
               else if (link.addr >= REG_SEQ_FIRST && link.addr <= REG_SEQ_LAST)
                  d.slot[3'(link.addr - REG_SEQ_FIRST)] = link.wdata;
               else if (link.addr == REG_FIRE)
                  d.fireBit = link.wdata[FIRE_BIT]; // RULE_02 RULE_19
               else if (link.addr >= REG_CFG_FIRST && link.addr <= REG_CFG_LAST)
                  d.cfg[3'(link.addr - REG_CFG_FIRST)] = link.wdata;
               else if (link.addr == REG_GATE)
                  d.gate = link.wdata;
            end
         end
         // external trigger; falling edges are simply not looked at in edge mode
         if (mode == MODE_EDGE && trigRise)
            d.fireBit = !q.fireBit; // RULE_01 RULE_03 RULE_04
         if (mode == MODE_LEVEL)
            d.fireBit = trigLvl; // RULE_05 RULE_20
         // faults; a fresh overheat wins over the clear-on-read
         if (overTemp)
            d.hotFlag = 1'b1; // RULE_10
         if (running && shortDet)
            d.shortFlag = 1'b1; // RULE_11
         d.check = (q.check == 32'(CHECK_CYCLES - 1)) ? 32'h0 : q.check + 32'h1;
         if (q.shortFlag && q.check == 32'h0 && !shortDet)
            d.shortFlag = 1'b0; // RULE_11
         // sequencer
         if (!fire)
            d.seqDone = 1'b0;
         if (!up || !fire)
         begin
            d.st = SIDLE; // RULE_02 RULE_05 RULE_12 RULE_15
            if (!up && mode != MODE_LEVEL)
               d.fireBit = 1'b0; // RULE_15
         end
         else
         begin
            case (q.st)
               SIDLE:
               begin
                  if (!cont && !q.seqDone && !q.shortBlock)
                  begin
                     if (shortDet)
                        d.shortBlock = 1'b1; // RULE_22
                     else if (mode == MODE_CAL || mode == MODE_DIAG)
                        d.st = SPROC; // RULE_18
                     else if (mode != MODE_INPUT)
                     begin
                        d.idx = 4'h0; // RULE_18
                        d.st = SNEXT;
                     end
                  end
               end
               SNEXT:
               begin
                  if (q.idx == 4'(SEQ_SLOTS) || slotVal == ZERO8)
                  begin
                     d.st = SIDLE; // RULE_23
                     d.seqDone = 1'b1;
                     if (mode != MODE_LEVEL)
                        d.fireBit = 1'b0; // RULE_19
                  end
                  else if (slotVal[SLOT_WAIT_BIT])
                  begin
                     d.steps = slotVal[6:0]; // RULE_23
                     d.tick = 32'h0;
                     d.st = SWAIT;
                  end
                  else
                     d.st = SPLAY;
               end
               SPLAY:
               begin
                  if (waveDone)
                  begin
                     d.idx = q.idx + 4'h1;
                     d.st = SNEXT;
                  end
               end
               SWAIT:
               begin
                  d.tick = q.tick + 32'h1;
                  if (q.steps == 7'h0)
                  begin
                     d.idx = q.idx + 4'h1;
                     d.st = SNEXT;
                  end
                  else if (q.tick == 32'(STEP_CYCLES - 1))
                  begin
                     d.tick = 32'h0; // RULE_23
                     d.steps = q.steps - 7'h1;
                  end
               end
               SPROC:
               begin
                  if (procDone)
                  begin
                     d.st = SIDLE; // RULE_18
                     d.seqDone = 1'b1;
                     d.fireBit = 1'b0;
                  end
               end
               default:
                  d.st = SIDLE;
            endcase
         end
         // outputs
         d.active = up; // RULE_12
         d.playing = up && (running || cont);
         d.waveId = (q.st == SPLAY) ? slotVal[6:0] : 7'h0;
         d.calRun = up && q.st == SPROC && mode == MODE_CAL;
         d.diagRun = up && q.st == SPROC && mode == MODE_DIAG;
         d.driveAmp = ZERO8;
         if (up && mode == MODE_REALTIME)
            d.driveAmp = q.realtime_amplitude_mode;
         else if (up && mode == MODE_INPUT && inputAmp >= thresh)
            d.driveAmp = inputAmp; // RULE_07
         if (q.playing)
            d.supply = supplyLevel; // RULE_08
      end
   end
   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= '0;
         q.modeReg <= MODE_RESET; // RULE_14
         q.otpLoad <= 1'b1;
      end
      else
         q <= d;
   end
   assign link.ack = q.ack;
   assign link.rdata = q.rdata;
   assign playing = q.playing;
   assign waveId = q.waveId;
   assign driveAmp = q.driveAmp;
   assign calRun = q.calRun;
   assign diagRun = q.diagRun;
   assign active = q.active;
endmodule : hap_device
`default_nettype wire

// ===== rtl/hap_host.sv
// host controller end: AHB-Lite registers driving the enable and trigger pins and register commands
`timescale 1ns/1ps
`default_nettype none
module hap_host
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // link to device
   hap_link_if.host link
);
   import hap_pkg::*;
   typedef struct packed {
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] rdata;
      logic enPin;
      logic trigPin;
      logic [7:0] pulse;
      logic busy;
      logic refused;
      logic req;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] result;
   } hap_host_t;
   hap_host_t q, d;
   logic [2:0] unusedSize;
   assign unusedSize = hsize;
   always_comb
   begin
      d = q;
      d.req = 1'b0;
      d.wrPend = 1'b0;
      // address phase; zero wait states, read data ready for the data phase
      if (hsel && hready && htrans[1])
      begin
         d.wrPend = hwrite;
         d.wrAddr = haddr[7:0];
         d.rdata = 32'h0;
         if (haddr[7:0] == HOST_CTRL)
         begin
            d.rdata[CTRL_EN_BIT] = q.enPin;
            d.rdata[CTRL_TRIG_BIT] = q.trigPin;
         end
         else if (haddr[7:0] == HOST_STAT)
         begin
            d.rdata[STAT_BUSY_BIT] = q.busy;
            d.rdata[STAT_REFUSED_BIT] = q.refused;
            d.rdata[STAT_DATA_LSB +: 8] = q.result;
         end
      end
      // trigger pulse long enough to be seen by the device
      if (q.pulse != 8'h0)
      begin
         d.pulse = q.pulse - 8'h1;
         if (q.pulse == 8'h1)
            d.trigPin = 1'b0;
      end
      // data phase of a write
      if (q.wrPend)
      begin
         if (q.wrAddr == HOST_CTRL)
         begin
            d.enPin = hwdata[CTRL_EN_BIT]; // RULE_12
            d.trigPin = hwdata[CTRL_TRIG_BIT]; // RULE_06
            if (hwdata[CTRL_PULSE_BIT])
            begin
               d.trigPin = 1'b1; // RULE_04
               d.pulse = 8'(TRIG_PULSE_CYCLES);
            end
         end
         else if (q.wrAddr == HOST_CMD && !q.busy)
         begin
            // device registers cannot be written with enable low, so refuse here
            if (hwdata[CMD_WRITE_BIT] && !q.enPin)
               d.refused = 1'b1; // RULE_13
            else
            begin
               d.refused = 1'b0;
               d.busy = 1'b1; // RULE_02 RULE_19 RULE_22
               d.req = 1'b1;
               d.we = hwdata[CMD_WRITE_BIT];
               d.addr = hwdata[15:8];
               d.wdata = hwdata[7:0];
            end
         end
      end
      if (q.busy && link.ack)
      begin
         d.busy = 1'b0;
         if (!q.we)
            d.result = link.rdata;
      end
   end
   always_ff @(posedge clk)
   begin
      if (srst)
         q <= '0;
      else
         q <= d;
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign link.enPin = q.enPin;
   assign link.trigPin = q.trigPin;
   assign link.req = q.req;
   assign link.we = q.we;
   assign link.addr = q.addr;
   assign link.wdata = q.wdata;
endmodule : hap_host
`default_nettype wire

// ===== test/hap_link_sva.sv
// link checker for the host and device pair
`timescale 1ns/1ps
`default_nettype none
module hap_link_sva
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link
   input wire logic trigPin,
   input wire logic enPin,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   a_ack_after_req: assert property (req |=> ack) else $error("no ack");
   a_ack_cause: assert property (ack |-> $past(req)) else $error("stray ack");
   a_ack_single: assert property (ack |=> !ack) else $error("long ack");
   // the enable pin passes two sync flops, so it must be low for four edges
   a_closed_zero: assert property (
      req && !we && !enPin && !$past(enPin) && !$past(enPin, 2) && !$past(enPin, 3) |=> rdata == 8'h00)
      else $error("read while disabled");
   a_write_enabled: assert property (req && we |-> enPin) else $error("write while disabled");
   a_cmd_held: assert property (!req |-> $stable({we, addr, wdata})) else $error("command moved");
   a_one_cmd: assert property (req |=> !req [*2]) else $error("second command too soon");
   a_reset_quiet: assert property ($fell(srst) |-> !req && !ack && !enPin && !trigPin)
      else $error("link busy after reset");
endmodule : hap_link_sva
`default_nettype wire

// ===== test/hap_tb.sv
// bench: bus master drives the host end, which drives the device end
`timescale 1ns/1ps
`default_nettype none
module tb;
   import hap_pkg::*;
   // ---
   // signals
   // ---
   logic clk, srst, hsel, hwrite, hready;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic overTemp, otpWritten, waveDone, procDone, playing, calRun, diagRun, active, shortDet;
   logic [7:0] supplyLevel, inputAmp, driveAmp;
   logic [6:0] waveId;
   logic [39:0] otpImage;
   int error_cnt, num_checks;
   hap_link_if lnk ();
   hap_host u_hap_host (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata), .link(lnk));
   hap_device #(.STEP_CYCLES(20), .CHECK_CYCLES(8)) u_hap_device (.clk(clk), .srst(srst), .link(lnk),
      .overTemp(overTemp), .shortDet(shortDet), .supplyLevel(supplyLevel), .inputAmp(inputAmp),
      .otpWritten(otpWritten), .otpImage(otpImage), .waveDone(waveDone), .procDone(procDone), .playing(playing),
      .waveId(waveId), .driveAmp(driveAmp), .calRun(calRun), .diagRun(diagRun), .active(active));
   hap_link_sva u_hap_link_sva (.clk(clk), .srst(srst), .trigPin(lnk.trigPin), .enPin(lnk.enPin), .req(lnk.req),
      .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ---
   // tasks
   // ---
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // bounded wait so a stuck bus ends the run
   task automatic edge_rdy();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 64)
         begin
            error_cnt++;
            final_report();
         end
         @(posedge clk);
      end
   endtask : edge_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      r = hrdata;
   endtask : bus
   task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      logic [31:0] s;
      int n;
      bus(1'b1, HOST_CMD, {15'h0000, w, a, d}, s);
      for (n = 0; n < 20; n++)
      begin
         bus(1'b0, HOST_STAT, 32'h0, s);
         if (s[STAT_BUSY_BIT] === 1'b0)
            break;
      end
      if (n == 20)
      begin
         error_cnt++;
         final_report();
      end
      r = s[15:8];
   endtask : dev
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      dev(1'b1, a, d, r);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] r;
      dev(1'b0, a, 8'h00, r);
      chk(nm, r, e);
   endtask : rdc
   // pins pass the sync flops first
   task automatic ctrl(input logic [7:0] d);
      logic [31:0] s;
      bus(1'b1, HOST_CTRL, {24'h00_0000, d}, s);
      repeat (6) @(posedge clk);
   endtask : ctrl
   task automatic pulse(input logic proc);
      waveDone <= !proc;
      procDone <= proc;
      @(posedge clk);
      waveDone <= 1'b0;
      procDone <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse
   // ---
   // main sequence
   // ---
   initial
   begin
      logic [31:0] s;
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      overTemp = 1'b0;
      otpWritten = 1'b1;
      otpImage = 40'h55_44_33_22_11;
      waveDone = 1'b0;
      procDone = 1'b0;
      supplyLevel = 8'h00;
      shortDet = 1'b0;
      inputAmp = 8'h00;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      wr(REG_RTP, 8'h55);
      bus(1'b0, HOST_STAT, 32'h0, s);
      chk("refused", s[7:0] & 8'h03, 8'h02);
      rdc(REG_MODE, 8'h00, "closed read");
      ctrl(8'h01);
      rdc(REG_RTP, 8'h00, "rtp kept");
      rdc(REG_MODE, MODE_RESET, "mode reset");
      rdc(REG_CFG_LAST, otpImage[39:32], "otp");
      wr(REG_RTP, 8'h55);
      wr(REG_CFG_FIRST, 8'haa);
      wr(REG_MODE, 8'h80);
      rdc(REG_MODE, MODE_RESET, "soft reset");
      rdc(REG_RTP, 8'h00, "rtp default");
      rdc(REG_CFG_FIRST, otpImage[7:0], "otp reload");
      // id, two-step wait, id, empty slot ends queue
      wr(REG_SEQ_FIRST, 8'h11);
      wr(REG_SEQ_FIRST + 8'h01, 8'h82);
      wr(REG_SEQ_FIRST + 8'h02, 8'h23);
      wr(REG_MODE, {5'h00, MODE_INTERNAL});
      wr(REG_FIRE, 8'h01);
      rdc(REG_FIRE, 8'h01, "fire held");
      chk("first id", {1'b0, waveId}, 8'h11);
      pulse(1'b0);
      repeat (45) @(posedge clk);
      chk("after wait", {1'b0, waveId}, 8'h23);
      pulse(1'b0);
      chk("queue end", {7'h00, playing}, 8'h00);
      rdc(REG_FIRE, 8'h00, "fire done");
      wr(REG_FIRE, 8'h01);
      wr(REG_FIRE, 8'h00);
      chk("cancel", {7'h00, playing}, 8'h00);
      wr(REG_FIRE, 8'h01);
      wr(REG_MODE, MODE_RESET);
      chk("standby", {6'h00, active, playing}, 8'h00);
      // edge mode: a pulse's fall changes nothing
      wr(REG_MODE, {5'h00, MODE_EDGE});
      ctrl(8'h05);
      repeat (40) @(posedge clk);
      rdc(REG_FIRE, 8'h01, "edge start");
      chk("edge play", {7'h00, playing}, 8'h01);
      ctrl(8'h05);
      repeat (40) @(posedge clk);
      rdc(REG_FIRE, 8'h00, "edge cancel");
      ctrl(8'h05);
      wr(REG_FIRE, 8'h00);
      chk("host cancel", {7'h00, playing}, 8'h00);
      repeat (40) @(posedge clk);
      wr(REG_MODE, {5'h00, MODE_LEVEL});
      ctrl(8'h03);
      supplyLevel <= 8'ha5;
      rdc(REG_FIRE, 8'h01, "level high");
      rdc(REG_SUPPLY, 8'ha5, "supply");
      ctrl(8'h01);
      rdc(REG_FIRE, 8'h00, "level low");
      chk("level stop", {7'h00, playing}, 8'h00);
      for (int m = 6; m < 8; m++)
      begin
         wr(REG_MODE, 8'(m));
         wr(REG_FIRE, 8'h01);
         chk("process", {6'h00, calRun, diagRun}, (m == 7) ? 8'h02 : 8'h01);
         pulse(1'b1);
         chk("process end", {6'h00, calRun, diagRun}, 8'h00);
         wr(REG_FIRE, 8'h00);
      end
      wr(REG_GATE, 8'h01);
      wr(REG_MODE, {5'h00, MODE_INPUT});
      inputAmp <= GATE_LEVELS[1] - 8'h01;
      repeat (3) @(posedge clk);
      chk("gate shut", driveAmp, 8'h00);
      inputAmp <= GATE_LEVELS[1];
      repeat (3) @(posedge clk);
      chk("gate open", driveAmp, GATE_LEVELS[1]);
      wr(REG_MODE, {5'h00, MODE_REALTIME});
      rdc(REG_FIRE, 8'h00, "realtime fire");
      overTemp <= 1'b1;
      repeat (4) @(posedge clk);
      chk("hot", {7'h00, active}, 8'h00);
      overTemp <= 1'b0;
      rdc(REG_STATUS, 8'h02, "hot flag");
      rdc(REG_STATUS, 8'h00, "hot clear");
      wr(REG_MODE, {5'h00, MODE_INTERNAL});
      wr(REG_FIRE, 8'h01);
      shortDet <= 1'b1;
      rdc(REG_STATUS, 8'h01, "short flag");
      chk("short stop", {7'h00, active}, 8'h00);
      shortDet <= 1'b0;
      repeat (10) @(posedge clk);
      chk("short gone", {7'h00, active}, 8'h01);
      shortDet <= 1'b1;
      wr(REG_FIRE, 8'h01);
      shortDet <= 1'b0;
      chk("short block", {6'h00, active, playing}, 8'h02);
      wr(REG_MODE, {5'h00, MODE_EDGE});
      chk("mode resume", {7'h00, playing}, 8'h01);
      final_report();
   end
endmodule : tb
`default_nettype wire
